/* iso_dev_model.sv */
// Isolator and side-A slave model facing the host controller.
`timescale 1ns/10ps
module iso_dev_model #(parameter SETTLE = 300) (
   input wire pwr,
   input wire slave_side_ready_n,
   input wire fault_a_n,
   input wire [7:0] slave_tx,
   input wire chip_select_input_pin_n,
   input wire sclk_pin,
   input wire sdi_pin,
   input wire aux_pin,
   input wire return_data_output_enable_n,
   output wire return_data_output_pin,
   output wire fault_output_pin_n,
   output wire side_a_alive_flag,
   output wire aux_a,
   output reg [7:0] slave_rx
);
   reg [7:0] sh = 8'h00;
   reg last = 1'b0;
   wire off = chip_select_input_pin_n & return_data_output_enable_n;
   wire cs_a = pwr ? chip_select_input_pin_n : 1'b1;
   wire drv = pwr ? sh[7] : 1'b0;
   assign return_data_output_pin = off ? ~last : drv;
   always @(drv or off) if (!off) last = drv;
   assign fault_output_pin_n = pwr & fault_a_n;
   assign aux_a = pwr ? aux_pin : 1'b1;
   assign #(SETTLE) side_a_alive_flag = pwr & ~slave_side_ready_n;
   always @(negedge cs_a) sh <= slave_tx;
   always @(negedge sclk_pin) if (!cs_a) sh <= {sh[6:0], 1'b0};
   always @(posedge sclk_pin) if (!cs_a) slave_rx <= {slave_rx[6:0], sdi_pin};
endmodule

/* iso_spi_host.v */
// SPI master controller driving an isolating SPI buffer from its side-B pins.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`include "iso_spi_host_regs.vh"
// Contract
// - Low-rate channels toggle at most 25Mbps
// - Fast channels up to 200Mbps, skew bounded
// - Alive flags used only as slow status
// - Transfers start only after side A ready
// - Enable return data whenever any select asserted (code enables it only while CTRL_SHARED is set)
module iso_spi_host #(
   parameter WIDTH = 8
) (
   input wire core_clk,
   input wire rst_n,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   output reg chip_select_input_pin_n,
   output reg sclk_pin,
   output reg sdi_pin,
   output reg aux_pin,
   output reg return_data_output_enable_n,
   input wire return_data_output_pin,
   input wire fault_output_pin_n,
   input wire side_a_alive_flag
);
// ----------------------------------------
// Input synchronisers
// ----------------------------------------
// Fault resets to its idle high level so status shows no false fault.
localparam [2:0] SYNC_IDLE = 3'b010;
wire [2:0] pin_in = {side_a_alive_flag, fault_output_pin_n, return_data_output_pin};
wire [2:0] pin_sync;
genvar i;
generate
   for (i = 0; i < 3; i = i + 1) begin : sync_bit
      reg stage1;
      reg stage2;
      always @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            stage1 <= SYNC_IDLE[i];
            stage2 <= SYNC_IDLE[i];
         end else begin
            stage1 <= pin_in[i];
            stage2 <= stage1;
         end
      end
      assign pin_sync[i] = stage2;
   end
endgenerate
wire miso = pin_sync[0];
wire fault_n = pin_sync[1];
wire alive = pin_sync[2];
// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] ctrl;
reg [7:0] div;
reg [WIDTH-1:0] txdata;
reg [WIDTH-1:0] shreg;
reg [WIDTH-1:0] rxdata;
reg done;
reg refused;
reg busy;
reg gap;
reg [7:0] cnt;
reg [7:0] bits;
reg phase;
reg [7:0] lr_cnt;
reg [7:0] status;
wire start = wr && addr == `REG_CTRL && wdata[`CTRL_START];
always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      ctrl <= `CTRL_RESET;
      div <= `DIV_RESET;
      txdata <= {WIDTH{1'b0}};
   end else begin
      if (wr && addr == `REG_CTRL) begin
         ctrl <= {wdata[7:1], 1'b0};
      end else if (wr && addr == `REG_TXDATA) begin
         txdata <= wdata[WIDTH-1:0];
      end else if (wr && addr == `REG_DIV) begin
         div <= (wdata < `LOW_RATE_CYCLES) ? `LOW_RATE_CYCLES : wdata;
      end
   end
end
// ----------------------------------------
// Status word and read data
// ----------------------------------------
always @* begin
   status = 8'h00;
   status[`STAT_BUSY] = busy;
   status[`STAT_ALIVE] = alive;
   status[`STAT_FAULT] = ~fault_n;
   status[`STAT_DONE] = done;
   status[`STAT_REFUSED] = refused;
end
always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      rdata <= 8'h00;
   end else if (!rd) begin
      rdata <= 8'h00;
   end else if (addr == `REG_CTRL) begin
      rdata <= ctrl;
   end else if (addr == `REG_STATUS) begin
      rdata <= status;
   end else if (addr == `REG_TXDATA) begin
      rdata <= txdata;
   end else if (addr == `REG_RXDATA) begin
      rdata <= rxdata;
   end else if (addr == `REG_DIV) begin
      rdata <= div;
   end else begin
      rdata <= 8'h00;
   end
end
// ----------------------------------------
// Sticky status flags
// ----------------------------------------
wire refuse_now = start && !busy && !alive;
wire done_now = busy && gap && cnt == 8'h00;
always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      done <= 1'b0;
      refused <= 1'b0;
   end else begin
      if (done_now) begin
         done <= 1'b1;
      end else if (wr && addr == `REG_STATUS && wdata[`STAT_DONE]) begin
         done <= 1'b0;
      end
      if (refuse_now) begin
         refused <= 1'b1;
      end else if (wr && addr == `REG_STATUS && wdata[`STAT_REFUSED]) begin
         refused <= 1'b0;
      end
   end
end
// ----------------------------------------
// Auxiliary level and return data enable
// ----------------------------------------
always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      aux_pin <= 1'b1;
      return_data_output_enable_n <= 1'b1;
      lr_cnt <= 8'h00;
   end else begin
      if (lr_cnt != 8'h00) begin
         lr_cnt <= lr_cnt - 8'h01;
      end
      if (lr_cnt == 8'h00 && aux_pin != ctrl[`CTRL_AUX]) begin
         aux_pin <= ctrl[`CTRL_AUX];
         lr_cnt <= `LOW_RATE_CYCLES;
      end
      return_data_output_enable_n <= ~(ctrl[`CTRL_SHARED] &
         (ctrl[`CTRL_EXT_SEL] | ~chip_select_input_pin_n));
   end
end
// ----------------------------------------
// Transfer engine
// ----------------------------------------
always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      busy <= 1'b0;
      gap <= 1'b0;
      cnt <= 8'h00;
      bits <= 8'h00;
      phase <= 1'b0;
      shreg <= {WIDTH{1'b0}};
      rxdata <= {WIDTH{1'b0}};
      sclk_pin <= 1'b0;
      sdi_pin <= 1'b0;
      chip_select_input_pin_n <= 1'b1;
   end else begin
      if (start && !busy) begin
         if (alive) begin
            busy <= 1'b1;
            gap <= 1'b0;
            chip_select_input_pin_n <= ~wdata[`CTRL_SELECT];
            shreg <= txdata;
            sdi_pin <= txdata[WIDTH-1];
            bits <= 8'h00;
            cnt <= div;
            phase <= 1'b0;
         end
      end else if (busy) begin
         if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end else if (gap) begin
            gap <= 1'b0;
            busy <= 1'b0;
         end else begin
            cnt <= div;
            phase <= ~phase;
            if (!phase) begin
               sclk_pin <= 1'b1;
               shreg <= {shreg[WIDTH-2:0], miso};
            end else begin
               sclk_pin <= 1'b0;
               if (bits == WIDTH - 1) begin
                  // Chip select stays high for the low-rate spacing before busy drops.
                  gap <= 1'b1;
                  cnt <= `LOW_RATE_CYCLES;
                  rxdata <= shreg;
                  chip_select_input_pin_n <= 1'b1;
               end else begin
                  bits <= bits + 8'h01;
                  sdi_pin <= shreg[WIDTH-1];
               end
            end
         end
      end
   end
end
endmodule

/* iso_spi_host_chk_sva.sv */
// Pin checker for the isolated SPI host controller.
`timescale 1ns/10ps
module iso_spi_host_chk (
   input wire core_clk,
   input wire rst_n,
   input wire chip_select_input_pin_n,
   input wire sclk_pin,
   input wire aux_pin,
   input wire return_data_output_enable_n,
   input wire side_a_alive_flag
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   clk_in_frame_a: assert property (sclk_pin |-> !chip_select_input_pin_n)
      else $error("clock outside frame");
   start_alive_a: assert property ($fell(chip_select_input_pin_n) |->
      $past(side_a_alive_flag, 3))
      else $error("start while side A down");
   cs_gap_a: assert property ($rose(chip_select_input_pin_n) |=>
      $stable(chip_select_input_pin_n)[*4])
      else $error("chip select toggles too fast");
   aux_rate_a: assert property ($changed(aux_pin) |=> $stable(aux_pin)[*4])
      else $error("aux toggles too fast");
   clk_rate_a: assert property ($changed(sclk_pin) |=> $stable(sclk_pin)[*4])
      else $error("serial clock too fast");
   shared_enable_a: assert property (!chip_select_input_pin_n[*3] |->
      !return_data_output_enable_n)
      else $error("return data not enabled");
   cover property ($fell(chip_select_input_pin_n));
   cover property ($changed(aux_pin));
   cover property ($fell(side_a_alive_flag));
endmodule

/* iso_spi_host_regs.vh */
// Register offsets, field positions and timing counts for the isolated SPI host controller.
`ifndef ISO_SPI_HOST_REGS_VH
`define ISO_SPI_HOST_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_TXDATA 4'h2
`define REG_RXDATA 4'h3
`define REG_DIV 4'h4
// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_START 0
`define CTRL_SELECT 1
`define CTRL_AUX 2
`define CTRL_SHARED 3
`define CTRL_EXT_SEL 4
`define CTRL_RESET 8'h00
// ----------------------------------------
// Status fields
// ----------------------------------------
`define STAT_BUSY 0
`define STAT_ALIVE 1
`define STAT_FAULT 2
`define STAT_DONE 3
`define STAT_REFUSED 4
// ----------------------------------------
// Timing
// ----------------------------------------
`define LOW_RATE_MBPS 25
`define CLK_MHZ 100
`define LOW_RATE_CYCLES 8'h04
`define DIV_RESET 8'h04
`endif

/* testbench.sv */
// Self-checking bench for the isolated SPI host controller.
`timescale 1ns/10ps
module testbench;
   reg core_clk = 1'b0;
   reg rst_n = 1'b0;
   reg [3:0] addr = 4'h0;
   reg [7:0] wdata = 8'h00;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg pwr = 1'b1;
   reg slave_side_ready_n = 1'b0;
   reg fault_a_n = 1'b1;
   reg [7:0] slave_tx = 8'h00;
   wire [7:0] rdata, slave_rx;
   wire chip_select_input_pin_n, sclk_pin, sdi_pin, aux_pin, return_data_output_enable_n;
   wire return_data_output_pin, fault_output_pin_n, side_a_alive_flag, aux_a;
   integer mismatches = 0;
   integer cmp_count = 0;
   integer k, n;
   reg [7:0] v;
   reg [15:0] rows [0:2];
   iso_spi_host iso_spi_host_inst (.core_clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
      .chip_select_input_pin_n, .sclk_pin, .sdi_pin, .aux_pin, .return_data_output_enable_n,
      .return_data_output_pin, .fault_output_pin_n, .side_a_alive_flag);
   iso_dev_model iso_dev_model_inst (.pwr, .slave_side_ready_n, .fault_a_n, .slave_tx,
      .chip_select_input_pin_n, .sclk_pin, .sdi_pin, .aux_pin, .return_data_output_enable_n,
      .return_data_output_pin, .fault_output_pin_n, .side_a_alive_flag, .aux_a, .slave_rx);
   initial forever #5 core_clk = ~core_clk;
   task chk(input string nm, input [7:0] g, input [7:0] e);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task wreg(input [3:0] a, input [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   task rreg(input [3:0] a, output [7:0] d);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   initial begin
      rows[0] = 16'ha55a;
      rows[1] = 16'h00ff;
      rows[2] = 16'h8001;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      #1 chk("idle", {4'h0, chip_select_input_pin_n, sclk_pin, aux_pin,
         return_data_output_enable_n}, 8'h0b);
      repeat (20) @(posedge core_clk);
      rreg(4'h7, v);
      chk("unmapped", v, 8'h00);
      for (k = 0; k < 3; k = k + 1) begin
         slave_tx <= rows[k][7:0];
         wreg(4'h2, rows[k][15:8]);
         wreg(4'h0, 8'h0f);
         repeat (3) @(posedge core_clk);
         #1 chk("enable", {7'h00, return_data_output_enable_n}, 8'h00);
         v = 8'h00;
         for (n = 0; n < 200 && v[3] !== 1'b1; n = n + 1) rreg(4'h1, v);
         if (v[3] !== 1'b1) begin
            mismatches = mismatches + 1;
            wrap_up;
         end
         rreg(4'h3, v);
         chk("rx", v, rows[k][7:0]);
         chk("slave", slave_rx, rows[k][15:8]);
         wreg(4'h1, 8'h18);
      end
      slave_side_ready_n <= 1'b1;
      fault_a_n <= 1'b0;
      repeat (60) @(posedge core_clk);
      wreg(4'h0, 8'h0f);
      repeat (3) @(posedge core_clk);
      #1 chk("select", {7'h00, chip_select_input_pin_n}, 8'h01);
      rreg(4'h1, v);
      chk("status", v & 8'h16, 8'h14);
      wreg(4'h0, 8'h0a);
      repeat (3) @(posedge core_clk);
      #1 chk("aux", {7'h00, aux_a}, 8'h00);
      wrap_up;
   end
endmodule
bind iso_spi_host iso_spi_host_chk iso_spi_host_chk_inst (.core_clk, .rst_n,
   .chip_select_input_pin_n, .sclk_pin, .aux_pin, .return_data_output_enable_n,
   .side_a_alive_flag);
